// ==== common/pfc_pkg.sv ====
// shared constants and types for the pfc fault supervisor
package pfc_pkg;
	localparam int CLK_MHZ = 100;
	// fault timing, each time in its own unit, then in clock cycles
	localparam int BROWNOUT_MS = 56;
	localparam int BROWNOUT_CYC = BROWNOUT_MS * 1000 * CLK_MHZ;
	localparam real RESTART_MS = 1.6;
	localparam int RESTART_CYC = int'(RESTART_MS * 1000.0 * CLK_MHZ);
	localparam int OPP_MS = 112;
	localparam int OPP_CYC = OPP_MS * 1000 * CLK_MHZ;
	localparam real SHUTDOWN_S = 2.5;
	localparam int SHUTDOWN_CYC = int'(SHUTDOWN_S * 1000000.0 * CLK_MHZ);
	localparam int PEAK_WINDOW_MS = 12;
	localparam int PEAK_WINDOW_CYC = PEAK_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int OPP_GAP_MS = 10;
	localparam int OPP_GAP_CYC = OPP_GAP_MS * 1000 * CLK_MHZ;
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
	// sense currents, one lsb is 0.1 ua
	localparam int CUR_W = 16;
	localparam logic [15:0] BROWNOUT_LOW = 16'h013c;
	localparam logic [15:0] BROWNOUT_HIGH = 16'h018c;
	localparam logic [15:0] FB_REFERENCE = 16'h050a;
	localparam logic [15:0] OVP_HYST = 16'h0014;
	localparam int OVP_PCT = 105;
	localparam int STARTUP_PCT = 90;
	// register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] FAULT_OFS = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_RUN = 0;
	localparam int STAT_GATE = 0;
	localparam int STAT_STARTUP = 1;
	localparam int STAT_OVP = 2;
	localparam int STAT_LOOP = 3;
	localparam int STAT_LOWPWR = 4;
	localparam int STAT_STATE = 8;
	localparam int FLT_BROWNOUT = 0;
	localparam int FLT_OVP = 1;
	localparam int FLT_LIMIT = 2;
	localparam int FLT_CLAMP = 3;
	localparam int FLT_OPP = 4;
	localparam int FLT_LOOP = 5;
	localparam int FLT_W = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_STANDBY = 4'h2,
		ST_RESTART = 4'h4,
		ST_SHUTDOWN = 4'h8
	} sup_state_t;
endpackage

// ==== common/timer_if.sv ====
// run request and expiry between supervisor and a fault timer
`timescale 1ns/10ps
interface timer_if;
	logic run;
	logic expired;
	modport ctl (output run, input expired);
	modport tmr (input run, output expired);
endinterface

// ==== rtl/fault_timer.sv ====
// cycle counting fault timer, cleared whenever its run request drops
`timescale 1ns/10ps
module fault_timer #(
	parameter int LIMIT = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	timer_if.tmr t
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] TOP = W'(LIMIT);
	logic [W-1:0] cnt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
		end else if (ce) begin
			if (!t.run) begin
				cnt <= '0;
			end else if (cnt != TOP) begin
				cnt <= cnt + 1'b1;
			end
		end
	end
	assign t.expired = t.run && (cnt == TOP);

	property p_timer_clear;
		@(posedge aclk) disable iff (!aresetn)
		ce && !t.run |=> cnt == '0;
	endproperty
	a_timer_clear: assert property (p_timer_clear)
		else $error("timer not cleared after run dropped");

	property p_timer_no_early;
		@(posedge aclk) disable iff (!aresetn)
		t.expired |-> $past(t.run) && cnt == TOP;
	endproperty
	a_timer_no_early: assert property (p_timer_no_early)
		else $error("timer expired before its full count");
endmodule

// ==== rtl/pfc_fault_supervisor.sv ====
// fault supervision and gate inhibit for the pfc boost switch
// What this block does
// - brownout judged on the peak of the rectified line current
// - peak below low level starts timer; brownout declared after 56 ms
// - brownout enters standby; recovery returns to normal mode
// - brownout left only after line stays above high level 56 ms
// - brownout levels are 31.6 ua low and 39.6 ua high
// - feedback above 105 percent of reference stops gate at once
// - after overvoltage, resume only below threshold minus hysteresis
// - switch current watched only while on, ignored during blanking
// - current limit trip ends the present on period at once
// - severe current: gate off, restart mode, 1.6 ms block, retry
// - link below startup level enters startup, cancelled at nominal
// - overload lasting past 112 ms shuts down 2.5 s then restarts
// - gate stopped when measured output is below measured line
// - loop fault clears when feedback at least line and above peak
// - loop fault caught well within 150 us
// - over-temperature resets all logic; restart once it clears
// - low standby pin puts device in a non-operating low-power state
// - startup below 90 percent of nominal, held until 100 percent
// - feedback compared to fixed 129 ua reference
`timescale 1ns/10ps
module pfc_fault_supervisor #(
	parameter int BROWNOUT_CYC = pfc_pkg::BROWNOUT_CYC,
	parameter int RESTART_CYC = pfc_pkg::RESTART_CYC,
	parameter int OPP_CYC = pfc_pkg::OPP_CYC,
	parameter int SHUTDOWN_CYC = pfc_pkg::SHUTDOWN_CYC,
	parameter int PEAK_WINDOW_CYC = pfc_pkg::PEAK_WINDOW_CYC,
	parameter int OPP_GAP_CYC = pfc_pkg::OPP_GAP_CYC,
	parameter int BLANK_CYC = pfc_pkg::BLANK_CYC,
	parameter logic [15:0] OVP_HYST = pfc_pkg::OVP_HYST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [15:0] line_sense_input,
	input wire logic [15:0] link_feedback_input,
	input wire logic pwm_request,
	input wire logic cs_limit_cmp,
	input wire logic cs_clamp_cmp,
	input wire logic over_temp,
	input wire logic standby_n,
	output logic gate_drive_output,
	output logic startup_mode,
	output logic low_power_mode,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam logic [15:0] OVP_THR =
		16'(32'(pfc_pkg::FB_REFERENCE) * pfc_pkg::OVP_PCT / 100);
	localparam logic [15:0] STARTUP_THR =
		16'(32'(pfc_pkg::FB_REFERENCE) * pfc_pkg::STARTUP_PCT / 100);
	localparam int PW = $clog2(PEAK_WINDOW_CYC + 1);
	localparam int BW = $clog2(BLANK_CYC + 1);

	// over-temperature cuts power to the logic: treated as a reset
	logic rst_n;
	assign rst_n = aresetn && !over_temp;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!rst_n);

	function automatic logic [15:0] sub_sat(input logic [15:0] a,
		input logic [15:0] b);
		sub_sat = (a > b) ? a - b : 16'h0000;
	endfunction

	// standby pin synchroniser
	logic standby_n_meta, standby_n_sync;
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			standby_n_meta <= 1'b1;
			standby_n_sync <= 1'b1;
		end else if (ce) begin
			standby_n_meta <= standby_n;
			standby_n_sync <= standby_n_meta;
		end
	end
	wire standby_req = !standby_n_sync;

	// line peak: running max over a window longer than a half cycle
	logic [15:0] run_max, line_peak;
	logic [PW-1:0] win_cnt;
	wire win_end = (win_cnt == PW'(PEAK_WINDOW_CYC - 1));
	wire [15:0] next_max =
		(line_sense_input > run_max) ? line_sense_input : run_max;
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			run_max <= '0;
			line_peak <= '0;
			win_cnt <= '0;
		end else if (ce) begin
			win_cnt <= win_end ? '0 : win_cnt + 1'b1;
			run_max <= win_end ? '0 : next_max;
			if (win_end) begin
				line_peak <= next_max;
			end
		end
	end

	// supervisor state and timers
	pfc_pkg::sup_state_t state, next_state;
	timer_if bo_in ();
	timer_if bo_out ();
	timer_if rst_t ();
	timer_if opp_t ();
	timer_if shut_t ();
	timer_if gap_t ();
	fault_timer #(.LIMIT(BROWNOUT_CYC)) u_bo_in (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(bo_in));
	fault_timer #(.LIMIT(BROWNOUT_CYC)) u_bo_out (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(bo_out));
	fault_timer #(.LIMIT(RESTART_CYC)) u_restart (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(rst_t));
	fault_timer #(.LIMIT(OPP_CYC)) u_opp (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(opp_t));
	fault_timer #(.LIMIT(SHUTDOWN_CYC)) u_shutdown (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(shut_t));
	fault_timer #(.LIMIT(OPP_GAP_CYC)) u_gap (.aclk(aclk),
		.aresetn(rst_n), .ce(ce), .t(gap_t));

	wire in_normal = (state == pfc_pkg::ST_NORMAL);
	logic ovl_seen;
	assign bo_in.run = in_normal && line_peak < pfc_pkg::BROWNOUT_LOW;
	assign bo_out.run = (state == pfc_pkg::ST_STANDBY) &&
		line_peak > pfc_pkg::BROWNOUT_HIGH;
	assign rst_t.run = (state == pfc_pkg::ST_RESTART);
	assign shut_t.run = (state == pfc_pkg::ST_SHUTDOWN);
	// short gaps between startup episodes still count as one overload
	assign gap_t.run = in_normal && ovl_seen && !startup_mode;
	assign opp_t.run = in_normal && ovl_seen &&
		(startup_mode || !gap_t.expired);

	// switch current checks, blanked at the start of each on period
	logic [BW-1:0] blank_cnt;
	wire blank_done = (blank_cnt == BW'(BLANK_CYC));
	wire cs_armed = gate_drive_output && blank_done;
	wire limit_trip = cs_armed && cs_limit_cmp;
	wire clamp_trip = cs_armed && cs_clamp_cmp;

	always_comb begin
		next_state = state;
		case (state)
			pfc_pkg::ST_NORMAL: begin
				if (clamp_trip) begin
					next_state = pfc_pkg::ST_RESTART;
				end else if (opp_t.expired) begin
					next_state = pfc_pkg::ST_SHUTDOWN;
				end else if (bo_in.expired) begin
					next_state = pfc_pkg::ST_STANDBY;
				end
			end
			pfc_pkg::ST_STANDBY: begin
				if (bo_out.expired) begin
					next_state = pfc_pkg::ST_NORMAL;
				end
			end
			pfc_pkg::ST_RESTART: begin
				if (rst_t.expired) begin
					next_state = pfc_pkg::ST_NORMAL;
				end
			end
			pfc_pkg::ST_SHUTDOWN: begin
				if (shut_t.expired) begin
					next_state = pfc_pkg::ST_NORMAL;
				end
			end
			default: next_state = pfc_pkg::ST_NORMAL;
		endcase
	end

	// link condition flags
	logic ovp_hold, loop_fault, cycle_kill;
	wire ovp_now = link_feedback_input > OVP_THR;
	wire ovp_clear = link_feedback_input < sub_sat(OVP_THR, OVP_HYST);
	wire loop_now = link_feedback_input < line_sense_input;
	wire loop_clear = link_feedback_input >= line_sense_input &&
		link_feedback_input > line_peak;
	wire leave_shutdown = shut_t.expired;

	// control register bit that software uses to allow switching
	logic [31:0] ctrl;
	logic [pfc_pkg::FLT_W-1:0] fault_log;
	wire gate_permit = in_normal && !ovp_now && !ovp_hold && !loop_now &&
		!loop_fault && !standby_req && ctrl[pfc_pkg::CTRL_RUN];
	wire next_gate = pwm_request && gate_permit && !cycle_kill &&
		!limit_trip && !clamp_trip;

	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			state <= pfc_pkg::ST_NORMAL;
			gate_drive_output <= 1'b0;
			ovp_hold <= 1'b0;
			loop_fault <= 1'b0;
			cycle_kill <= 1'b0;
			blank_cnt <= '0;
			startup_mode <= 1'b1;
			ovl_seen <= 1'b0;
			low_power_mode <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			gate_drive_output <= next_gate;
			ovp_hold <= ovp_now || (ovp_hold && !ovp_clear);
			loop_fault <= loop_now || (loop_fault && !loop_clear);
			// a tripped on period stays off until the pwm request ends
			cycle_kill <= pwm_request && (cycle_kill || limit_trip);
			blank_cnt <= !gate_drive_output ? '0 :
				(blank_done ? blank_cnt : blank_cnt + 1'b1);
			if (leave_shutdown) begin
				startup_mode <= 1'b1;
			end else if (link_feedback_input < STARTUP_THR) begin
				startup_mode <= 1'b1;
			end else if (link_feedback_input >= pfc_pkg::FB_REFERENCE) begin
				startup_mode <= 1'b0;
			end
			if (leave_shutdown) begin
				ovl_seen <= 1'b0;
			end else if (!startup_mode) begin
				ovl_seen <= 1'b1;
			end
			low_power_mode <= standby_req ||
				next_state == pfc_pkg::ST_STANDBY;
		end
	end

	// axi4-lite slave
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign awready = ce && !aw_held && !bvalid;
	assign wready = ce && !w_held && !bvalid;
	assign arready = ce && !rvalid;
	wire do_write = ce && aw_held && w_held && !bvalid;
	wire wr_ctrl = do_write && aw_addr == pfc_pkg::CTRL_OFS;
	wire wr_fault = do_write && aw_addr == pfc_pkg::FAULT_OFS;
	wire wr_ok = wr_ctrl || wr_fault ||
		(aw_addr == pfc_pkg::STATUS_OFS);
	wire [31:0] status_word = {20'h0000_0, state, 3'h0, low_power_mode,
		loop_fault, ovp_hold || ovp_now, startup_mode, gate_drive_output};
	wire [pfc_pkg::FLT_W-1:0] fault_set = {loop_now,
		state == pfc_pkg::ST_SHUTDOWN, clamp_trip, limit_trip, ovp_now,
		state == pfc_pkg::ST_STANDBY};
	wire [pfc_pkg::FLT_W-1:0] fault_clr =
		(wr_fault && w_strb[0]) ? w_data[pfc_pkg::FLT_W-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= pfc_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= pfc_pkg::RESP_OKAY;
			ctrl <= pfc_pkg::CTRL_RESET;
			fault_log <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? pfc_pkg::RESP_OKAY : pfc_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (wr_ctrl && w_strb[0]) begin
				ctrl[7:0] <= w_data[7:0];
			end
			// a new event wins over a software clear in the same cycle
			fault_log <= (fault_log & ~fault_clr) | fault_set;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= pfc_pkg::RESP_OKAY;
				if (araddr == pfc_pkg::CTRL_OFS) begin
					rdata <= ctrl;
				end else if (araddr == pfc_pkg::STATUS_OFS) begin
					rdata <= status_word;
				end else if (araddr == pfc_pkg::FAULT_OFS) begin
					rdata <= {26'h000_0000, fault_log};
				end else begin
					rdata <= '0;
					rresp <= pfc_pkg::RESP_SLVERR;
				end
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	property p_ovp_stop;
		ce && ovp_now |=> !gate_drive_output;
	endproperty
	a_ovp_stop: assert property (p_ovp_stop)
		else $error("gate drive kept on during overvoltage");

	property p_ovp_resume;
		ce && ovp_hold && !ovp_clear |=> ovp_hold ##0 !gate_drive_output;
	endproperty
	a_ovp_resume: assert property (p_ovp_resume)
		else $error("overvoltage released above hysteresis band");

	property p_blank;
		gate_drive_output && !$past(gate_drive_output) |-> !cs_armed;
	endproperty
	a_blank: assert property (p_blank)
		else $error("current check armed in blanking interval");

	property p_limit;
		ce && limit_trip |=> !gate_drive_output;
	endproperty
	a_limit: assert property (p_limit)
		else $error("on period not ended on current limit");

	property p_clamp;
		ce && in_normal && clamp_trip |=>
			state == pfc_pkg::ST_RESTART ##1 !gate_drive_output[*8];
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("severe current did not enter restart");

	property p_brownout;
		$rose(state == pfc_pkg::ST_STANDBY) |-> $past(bo_in.expired);
	endproperty
	a_brownout: assert property (p_brownout)
		else $error("standby entered before brownout timer expired");

	property p_standby_gate;
		state == pfc_pkg::ST_STANDBY || standby_req |=> !gate_drive_output;
	endproperty
	a_standby_gate: assert property (p_standby_gate)
		else $error("gate drive active in standby");

	property p_shutdown;
		$rose(state == pfc_pkg::ST_SHUTDOWN) |-> $past(opp_t.expired);
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown without sustained overload");

	property p_loop;
		ce && loop_now |=> loop_fault && !gate_drive_output;
	endproperty
	a_loop: assert property (p_loop)
		else $error("loop fault did not stop gate drive");

	property p_startup;
		$rose(startup_mode) |-> $past(link_feedback_input) < STARTUP_THR ||
			$past(leave_shutdown) || !$past(rst_n);
	endproperty
	a_startup: assert property (p_startup)
		else $error("startup entered above startup level");

	property p_permit;
		gate_drive_output |-> $past(gate_permit);
	endproperty
	a_permit: assert property (p_permit)
		else $error("gate on while an inhibit was active");
endmodule

// ==== verif/pfc_power_stage.sv ====
// boost stage and sense network model facing the fault supervisor
`timescale 1ns/10ps
module pfc_power_stage (
	input wire logic aclk,
	input wire logic gate_drive_output,
	input wire logic [15:0] line_lvl,
	input wire logic [15:0] fb_lvl,
	input wire logic pull_low,
	input wire logic limit_arm,
	input wire logic clamp_arm,
	output logic [15:0] line_sense_input,
	output logic [15:0] link_feedback_input,
	output logic cs_limit_cmp,
	output logic cs_clamp_cmp,
	output wire logic standby_n
);
	int on_cnt = 0;
	// open drain with pull-up: a released pin reads high
	assign standby_n = pull_low ? 1'b0 : 1'b1;
	assign line_sense_input = line_lvl;
	assign link_feedback_input = fb_lvl;
	// shunt current flows only while the switch is on
	assign cs_limit_cmp = gate_drive_output & limit_arm;
	// severe spike arrives after blanking so it cannot be masked
	assign cs_clamp_cmp = gate_drive_output & clamp_arm & (on_cnt >= 5);
	always_ff @(posedge aclk) begin
		on_cnt <= gate_drive_output ? on_cnt + 1 : 0;
	end
endmodule

// ==== verif/pfc_fault_supervisor_tb_top.sv ====
// self-checking bench for the pfc fault supervisor
`timescale 1ns/10ps
module pfc_fault_supervisor_tb_top;
	localparam int BLANK = 3;
	logic aclk = 0, aresetn = 0, ce = 1, pwm_request = 0, over_temp = 0;
	logic [15:0] line_lvl = 16'h03e8, fb_lvl = 16'h0514;
	logic pull_low = 0, limit_arm = 0, clamp_arm = 0;
	logic [15:0] line_sense_input, link_feedback_input;
	logic cs_limit_cmp, cs_clamp_cmp, standby_n;
	logic gate_drive_output, startup_mode, low_power_mode;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd, r;
	int fails = 0, check_count = 0, seed = 78558, n, k;
	logic q[$];
	pfc_fault_supervisor #(.BROWNOUT_CYC(50), .RESTART_CYC(20),
		.OPP_CYC(60), .SHUTDOWN_CYC(30), .PEAK_WINDOW_CYC(8),
		.OPP_GAP_CYC(10), .BLANK_CYC(BLANK)) uut (.aclk(aclk),
		.aresetn(aresetn), .ce(ce), .line_sense_input(line_sense_input),
		.link_feedback_input(link_feedback_input), .pwm_request(pwm_request),
		.cs_limit_cmp(cs_limit_cmp), .cs_clamp_cmp(cs_clamp_cmp),
		.over_temp(over_temp), .standby_n(standby_n),
		.gate_drive_output(gate_drive_output), .startup_mode(startup_mode),
		.low_power_mode(low_power_mode), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	pfc_power_stage stage (.aclk(aclk), .gate_drive_output(gate_drive_output),
		.line_lvl(line_lvl), .fb_lvl(fb_lvl), .pull_low(pull_low),
		.limit_arm(limit_arm), .clamp_arm(clamp_arm),
		.line_sense_input(line_sense_input),
		.link_feedback_input(link_feedback_input),
		.cs_limit_cmp(cs_limit_cmp), .cs_clamp_cmp(cs_clamp_cmp),
		.standby_n(standby_n));
	initial begin
		forever #5 aclk = ~aclk;
	end
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task hang(input string what);
		fails++;
		$display("Error %s expected answer seen timeout", what);
		give_verdict();
	endtask
	task cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	// sel 0 watches the gate, sel 1 low power; n counts cycles taken
	task wait_out(input int sel, input logic v, input int lim);
		for (n = 1; n <= lim; n++) begin
			@(posedge aclk);
			#1;
			if ((sel ? low_power_mode : gate_drive_output) === v) break;
		end
		if (n > lim) hang(sel ? "low_power" : "gate");
	endtask
	task axi_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ta, tw;
		i = 0;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			i++;
			if (awready === 1'b1) begin
				ta = 1;
				awvalid <= 0;
			end
			if (wready === 1'b1) begin
				tw = 1;
				wvalid <= 0;
			end
		end while (!(ta && tw) && i < 50);
		bready <= 1;
		do begin
			@(posedge aclk);
			i++;
		end while (bvalid !== 1'b1 && i < 100);
		rs = bresp;
		bready <= 0;
		if (i >= 100) hang("bvalid");
	endtask
	task axi_read(input logic [7:0] a);
		int i;
		i = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge aclk);
			i++;
		end while (arready !== 1'b1 && i < 50);
		arvalid <= 0;
		rready <= 1;
		do begin
			@(posedge aclk);
			i++;
		end while (rvalid !== 1'b1 && i < 100);
		rd = rdata;
		rs = rresp;
		rready <= 0;
		if (i >= 100) hang("rvalid");
	endtask
	initial begin
		cyc(5);
		aresetn <= 1;
		#1;
		check("gate", gate_drive_output, 0);
		check("startup", startup_mode, 1);
		check("low_power", low_power_mode, 0);
		axi_read(pfc_pkg::CTRL_OFS);
		check("ctrl", rd, pfc_pkg::CTRL_RESET);
		axi_read(8'h10);
		check("rresp", rs, pfc_pkg::RESP_SLVERR);
		check("rdata", rd, 0);
		axi_write(8'h10, 1);
		check("bresp", rs, pfc_pkg::RESP_SLVERR);
		axi_write(pfc_pkg::CTRL_OFS, 32'h0000_0081);
		axi_read(pfc_pkg::CTRL_OFS);
		check("ctrl", rd, 32'h0000_0081);
		check("startup", startup_mode, 0);
		$display("test registers done");
		// hysteresis on the startup band, 1160 / 1289 / 1290
		cyc(1);
		fb_lvl <= 16'h0488;
		cyc(3);
		fb_lvl <= 16'h0509;
		#1 check("startup", startup_mode, 1);
		cyc(3);
		fb_lvl <= 16'h050a;
		#1 check("startup", startup_mode, 1);
		cyc(3);
		#1 check("startup", startup_mode, 0);
		// queue model: gate repeats last cycle's request
		q.push_back(pwm_request);
		repeat (24) begin
			@(posedge aclk);
			r = $random(seed);
			pwm_request <= r[0];
			fb_lvl <= 16'h050a + 16'(r[31:16] % 16'd44);
			#1 check("gate", gate_drive_output, q.pop_front());
			q.push_back(r[0]);
		end
		$display("test gate follow done");
		@(posedge aclk);
		pwm_request <= 1;
		fb_lvl <= 16'h054b;
		wait_out(0, 0, 3);
		check("ovp_delay", n, 1);
		fb_lvl <= 16'h0536;
		cyc(4);
		#1 check("gate", gate_drive_output, 0);
		cyc(1);
		fb_lvl <= 16'h0535;
		wait_out(0, 1, 4);
		axi_read(pfc_pkg::FAULT_OFS);
		check("fault_ovp", rd[pfc_pkg::FLT_OVP], 1);
		axi_write(pfc_pkg::FAULT_OFS, 32'h0000_0002);
		axi_read(pfc_pkg::FAULT_OFS);
		check("fault_ovp", rd[pfc_pkg::FLT_OVP], 0);
		$display("test overvoltage done");
		cyc(1);
		line_lvl <= 16'h0536;
		wait_out(0, 0, 3);
		check("loop_delay", n, 1);
		line_lvl <= 16'h03e8;
		cyc(1);
		// line peak still holds the high sample
		#1 check("gate", gate_drive_output, 0);
		wait_out(0, 1, 40);
		$display("test loop fault done");
		cyc(1);
		pwm_request <= 0;
		cyc(2);
		limit_arm <= 1;
		pwm_request <= 1;
		wait_out(0, 1, 4);
		k = 1;
		repeat (20) begin
			@(posedge aclk);
			#1 k += (gate_drive_output === 1'b1);
		end
		check("on_cycles", k, BLANK + 1);
		cyc(1);
		limit_arm <= 0;
		pwm_request <= 0;
		cyc(2);
		pwm_request <= 1;
		wait_out(0, 1, 4);
		clamp_arm <= 1;
		wait_out(0, 0, 20);
		clamp_arm <= 0;
		wait_out(0, 1, 24);
		check("restart_len", 32'(n >= 18), 1);
		$display("test overcurrent done");
		cyc(1);
		line_lvl <= 16'h013b;
		wait_out(1, 1, 120);
		check("bo_entry", 32'(n >= 50), 1);
		// gate drops one edge after the state enters standby
		@(posedge aclk);
		#1 check("gate", gate_drive_output, 0);
		axi_read(pfc_pkg::STATUS_OFS);
		check("state", rd[11:8], 32'(pfc_pkg::ST_STANDBY));
		line_lvl <= 16'h018d;
		cyc(20);
		line_lvl <= 16'h013b;
		cyc(30);
		line_lvl <= 16'h018d;
		cyc(40);
		// a stale exit timer would already have fired here
		#1 check("low_power", low_power_mode, 1);
		wait_out(1, 0, 60);
		wait_out(0, 1, 4);
		$display("test brownout done");
		cyc(1);
		fb_lvl <= 16'h0488;
		wait_out(0, 0, 120);
		check("opp_time", 32'(n >= 60), 1);
		axi_read(pfc_pkg::STATUS_OFS);
		check("state", rd[11:8], 32'(pfc_pkg::ST_SHUTDOWN));
		fb_lvl <= 16'h0514;
		wait_out(0, 1, 60);
		axi_read(pfc_pkg::FAULT_OFS);
		check("fault_opp", rd[pfc_pkg::FLT_OPP], 1);
		$display("test overload done");
		cyc(1);
		pull_low <= 1;
		wait_out(1, 1, 5);
		wait_out(0, 0, 2);
		cyc(1);
		pull_low <= 0;
		wait_out(1, 0, 5);
		wait_out(0, 1, 5);
		$display("test standby done");
		// a cleared byte strobe leaves the control word alone
		wstrb <= 4'h0;
		axi_write(pfc_pkg::CTRL_OFS, 32'h0000_0000);
		wstrb <= 4'hf;
		axi_read(pfc_pkg::CTRL_OFS);
		check("ctrl", rd, 32'h0000_0081);
		axi_write(pfc_pkg::CTRL_OFS, 32'h0000_0000);
		wait_out(0, 0, 4);
		axi_write(pfc_pkg::CTRL_OFS, 32'h0000_0001);
		wait_out(0, 1, 4);
		// clock enable low freezes the gate and the bus
		@(posedge aclk);
		ce <= 0;
		pwm_request <= 0;
		cyc(3);
		#1 check("gate", gate_drive_output, 1);
		check("awready", awready, 0);
		ce <= 1;
		wait_out(0, 0, 2);
		$display("test control done");
		cyc(1);
		over_temp <= 1;
		cyc(1);
		over_temp <= 0;
		#1 check("gate", gate_drive_output, 0);
		check("startup", startup_mode, 1);
		axi_read(pfc_pkg::CTRL_OFS);
		check("ctrl", rd, pfc_pkg::CTRL_RESET);
		axi_read(pfc_pkg::FAULT_OFS);
		check("fault", rd, 0);
		$display("test over temperature done");
		give_verdict();
	end
endmodule
